// ---- logic/charger_thermal_zone_config.sv ----
// Thermal-zone configuration registers of the battery charger
`timescale 1ns/1ps
module charger_thermal_zone_config (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Charger input and restore option
    input  wire logic       charger_input,
    input  wire logic [1:0] input_valid_select,
    // Configuration outputs
    output logic      [1:0] thermistor_monitor_enable,
    output logic      [1:0] cool_zone_voltage_drop,
    output logic      [2:0] cool_zone_current_scale,
    output logic      [1:0] room_zone_voltage_drop,
    output logic      [2:0] room_zone_current_scale,
    // Decoded settings
    output logic      [3:0] cool_zone_current_tenths,
    output logic      [3:0] room_zone_current_tenths,
    output logic      [7:0] room_zone_drop_mv,
    output logic            defaults_restored
);

    // ------------------------------------------------------------
    // Charger input edges
    // ------------------------------------------------------------
    logic rise;
    logic fall;
    logic restore;

    charger_edge_sync u_edge (
        .clock  (clock),
        .rstn   (rstn),
        .pin_in (charger_input),
        .rise_q (rise),
        .fall_q (fall)
    );

    assign restore = (rise && input_valid_select[0]) ||
                     (fall && input_valid_select[1]);

    logic wr_cool;
    logic wr_room;
    assign wr_cool = reg_wr && (reg_addr == charger_thermal_pkg::COOL_ZONE_CFG_ADDR);
    assign wr_room = reg_wr && (reg_addr == charger_thermal_pkg::ROOM_ZONE_CFG_ADDR);

    // ------------------------------------------------------------
    // Cool-zone register
    // ------------------------------------------------------------
    // Restore beats a write in the same cycle: the plug event is the newer fact
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            thermistor_monitor_enable <= charger_thermal_pkg::THM_EN_DEFAULT;
            cool_zone_voltage_drop    <= charger_thermal_pkg::COOL_VDROP_DEFAULT;
            cool_zone_current_scale   <= charger_thermal_pkg::COOL_ISCALE_DEFAULT;
        end else if (restore) begin
            thermistor_monitor_enable <= charger_thermal_pkg::THM_EN_DEFAULT;
            cool_zone_voltage_drop    <= charger_thermal_pkg::COOL_VDROP_DEFAULT;
            cool_zone_current_scale   <= charger_thermal_pkg::COOL_ISCALE_DEFAULT;
        end else if (wr_cool) begin
            thermistor_monitor_enable <= reg_wdata[charger_thermal_pkg::THM_EN_MSB:charger_thermal_pkg::THM_EN_LSB];
            cool_zone_voltage_drop    <= reg_wdata[charger_thermal_pkg::VDROP_MSB:charger_thermal_pkg::VDROP_LSB];
            cool_zone_current_scale   <= reg_wdata[charger_thermal_pkg::ISCALE_MSB:charger_thermal_pkg::ISCALE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Room-zone register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            room_zone_voltage_drop  <= charger_thermal_pkg::ROOM_VDROP_DEFAULT;
            room_zone_current_scale <= charger_thermal_pkg::ROOM_ISCALE_DEFAULT;
        end else if (restore) begin
            room_zone_voltage_drop  <= charger_thermal_pkg::ROOM_VDROP_DEFAULT;
            room_zone_current_scale <= charger_thermal_pkg::ROOM_ISCALE_DEFAULT;
        end else if (wr_room) begin
            room_zone_voltage_drop  <= reg_wdata[charger_thermal_pkg::VDROP_MSB:charger_thermal_pkg::VDROP_LSB];
            room_zone_current_scale <= reg_wdata[charger_thermal_pkg::ISCALE_MSB:charger_thermal_pkg::ISCALE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unused bits are simply not stored, so they read back as zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                charger_thermal_pkg::COOL_ZONE_CFG_ADDR: begin
                    reg_rdata <= {1'b0, thermistor_monitor_enable,
                                  cool_zone_voltage_drop, cool_zone_current_scale};
                end
                charger_thermal_pkg::ROOM_ZONE_CFG_ADDR: begin
                    reg_rdata <= {3'h0, room_zone_voltage_drop, room_zone_current_scale};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------
    // Registered so the analog side sees clean levels, one cycle behind the field
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cool_zone_current_tenths <= charger_thermal_pkg::ISCALE_FULL_TENTH;
        end else begin
            cool_zone_current_tenths <= charger_thermal_pkg::current_tenths(cool_zone_current_scale);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            room_zone_current_tenths <= charger_thermal_pkg::ISCALE_FULL_TENTH;
        end else begin
            room_zone_current_tenths <= charger_thermal_pkg::current_tenths(room_zone_current_scale);
        end
    end

    // Room drop only; the cool drop decode is left to the analog side
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            room_zone_drop_mv <= 8'h00;
        end else begin
            room_zone_drop_mv <= charger_thermal_pkg::drop_mv(room_zone_voltage_drop);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            defaults_restored <= 1'b0;
        end else begin
            defaults_restored <= restore;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_restore_fields: assert property (
        restore |=> (thermistor_monitor_enable == charger_thermal_pkg::THM_EN_DEFAULT)
                 && (cool_zone_voltage_drop == charger_thermal_pkg::COOL_VDROP_DEFAULT)
                 && (room_zone_current_scale == charger_thermal_pkg::ROOM_ISCALE_DEFAULT)
                 && defaults_restored)
        else $error("fields not restored after charger input edge");

    a_restore_others: assert property (
        restore |=> (room_zone_voltage_drop == charger_thermal_pkg::ROOM_VDROP_DEFAULT)
                 && (cool_zone_current_scale == charger_thermal_pkg::COOL_ISCALE_DEFAULT))
        else $error("remaining fields not restored after charger input edge");

    // Edge without its select bit: neither current scale may move and no pulse may leave
    a_restore_select: assert property (
        ((rise && !input_valid_select[0]) || (fall && !input_valid_select[1])) && !wr_cool && !wr_room
            |=> $stable(cool_zone_current_scale) && $stable(room_zone_current_scale) && !defaults_restored)
        else $error("restore fired although option disabled it");

    a_cool_drop_write: assert property (
        wr_cool && !restore |=> cool_zone_voltage_drop == $past(reg_wdata[4:3]))
        else $error("cool zone voltage drop not written");

    a_cool_thm_write: assert property (
        wr_cool && !restore |=> thermistor_monitor_enable == $past(reg_wdata[6:5]))
        else $error("cool zone monitor enable not written");

    a_cool_hold: assert property (
        !wr_cool && !restore |=> $stable(thermistor_monitor_enable) && $stable(cool_zone_voltage_drop)
                                 && $stable(cool_zone_current_scale))
        else $error("cool zone fields changed without a write");

    a_room_hold: assert property (
        !wr_room && !restore |=> $stable(room_zone_voltage_drop) && $stable(room_zone_current_scale))
        else $error("room zone fields changed without a write");

    a_room_scale_write: assert property (
        wr_room && !restore |=> room_zone_current_scale == $past(reg_wdata[2:0]))
        else $error("room zone current scale not written");

    a_room_tenths_map: assert property (
        ##1 room_zone_current_tenths == (($past(room_zone_current_scale) == 3'h7) ? 4'hA
                                          : 4'($past(room_zone_current_scale)) + 4'h2))
        else $error("room zone current decode wrong");

    a_cool_tenths_map: assert property (
        ##1 cool_zone_current_tenths == (($past(cool_zone_current_scale) == 3'h7) ? 4'hA
                                          : 4'($past(cool_zone_current_scale)) + 4'h2))
        else $error("cool zone current decode wrong");

    a_cool_unused_zero: assert property (
        reg_rd && reg_addr == charger_thermal_pkg::COOL_ZONE_CFG_ADDR |=> reg_rdata[7] == 1'b0)
        else $error("cool zone unused bit read nonzero");

    a_room_unused_zero: assert property (
        reg_rd && reg_addr == charger_thermal_pkg::ROOM_ZONE_CFG_ADDR |=> reg_rdata[7:5] == 3'h0)
        else $error("room zone unused bits read nonzero");

    a_read_returns: assert property (
        reg_rd && !reg_wr && reg_addr == charger_thermal_pkg::ROOM_ZONE_CFG_ADDR
            |=> reg_rdata[2:0] == $past(room_zone_current_scale))
        else $error("room zone readback wrong");

    a_read_cool: assert property (
        reg_rd && !reg_wr && reg_addr == charger_thermal_pkg::COOL_ZONE_CFG_ADDR
            |=> reg_rdata[4:3] == $past(cool_zone_voltage_drop))
        else $error("cool zone readback wrong");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_restore_rise:   cover property (rise && input_valid_select[0]);
    c_edge_ignored:   cover property ((rise && !input_valid_select[0]) || (fall && !input_valid_select[1]));
    c_restore_fall:   cover property (fall && input_valid_select[1]);
    c_write_then_rd:  cover property (wr_room ##1 reg_rd && reg_addr == charger_thermal_pkg::ROOM_ZONE_CFG_ADDR);
    c_restore_vs_wr:  cover property (restore && (wr_cool || wr_room));

endmodule : charger_thermal_zone_config

// ---- pkg/charger_thermal_pkg.sv ----
// Constants for the charger thermal-zone configuration registers
// Functional notes
// - Charger input edge restores marked fields, per select
// - Cool register bits 4:3 hold voltage drop
// - Room register bits 2:0 hold current scale
// - Current codes map 0.2..0.8, 111 is 1.0
package charger_thermal_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] COOL_ZONE_CFG_ADDR = 8'h15;
    localparam logic [7:0] ROOM_ZONE_CFG_ADDR = 8'h16;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int THM_EN_LSB     = 5;
    localparam int THM_EN_MSB     = 6;
    localparam int VDROP_LSB      = 3;
    localparam int VDROP_MSB      = 4;
    localparam int ISCALE_LSB     = 0;
    localparam int ISCALE_MSB     = 2;

    // ------------------------------------------------------------
    // Values after reset and after a restore
    // ------------------------------------------------------------
    localparam logic [1:0] THM_EN_DEFAULT      = 2'h0;
    localparam logic [1:0] COOL_VDROP_DEFAULT  = 2'h0;
    localparam logic [2:0] COOL_ISCALE_DEFAULT = 3'h7;
    localparam logic [1:0] ROOM_VDROP_DEFAULT  = 2'h3;
    localparam logic [2:0] ROOM_ISCALE_DEFAULT = 3'h7;

    // ------------------------------------------------------------
    // Restore edge selection
    // ------------------------------------------------------------
    localparam logic [1:0] RESTORE_ON_RISE = 2'h1;
    localparam logic [1:0] RESTORE_ON_FALL = 2'h2;

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    localparam logic [2:0] ISCALE_FULL_CODE  = 3'h7;
    localparam logic [3:0] ISCALE_FULL_TENTH = 4'hA;
    localparam logic [3:0] ISCALE_BASE_TENTH = 4'h2;
    localparam logic [7:0] VDROP_STEP_MV     = 8'h32;

    // Fast-charge multiplier in tenths of the programmed current
    function automatic logic [3:0] current_tenths(input logic [2:0] code);
        current_tenths = (code == ISCALE_FULL_CODE) ? ISCALE_FULL_TENTH
                                                    : ({1'b0, code} + ISCALE_BASE_TENTH);
    endfunction : current_tenths

    // Regulation voltage drop in mV: 00 150, 01 100, 10 50, 11 0
    function automatic logic [7:0] drop_mv(input logic [1:0] code);
        drop_mv = 8'(VDROP_STEP_MV * (2'h3 - code));
    endfunction : drop_mv

endpackage : charger_thermal_pkg

// ---- logic/charger_edge_sync.sv ----
// Synchroniser and edge detector for the charger input pin
`timescale 1ns/1ps
module charger_edge_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Pin
    input  wire logic pin_in,
    // Edge pulses
    output logic      rise_q,
    output logic      fall_q
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= sync_q & ~prev_q;
            fall_q <= ~sync_q & prev_q;
        end
    end

endmodule : charger_edge_sync

// ---- verification/tb.sv ----
// Self-checking bench for the charger thermal-zone configuration registers
`timescale 1ns/1ps
module tb;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic       clock = 1'b0;
    logic       rstn  = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       charger_input = 1'b0;
    logic [1:0] input_valid_select = 2'h0;
    logic [1:0] thm_en, cool_drop, room_drop;
    logic [2:0] cool_scale, room_scale;
    logic [3:0] cool_tenths, room_tenths;
    logic [7:0] room_mv;
    logic       restored;
    int         err_total = 0;
    int         check_count = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rback;
        logic [3:0] tenths;
        logic [7:0] mv;
    } row_t;

    localparam logic [7:0] COOL_DEF = {1'b0, charger_thermal_pkg::THM_EN_DEFAULT,
        charger_thermal_pkg::COOL_VDROP_DEFAULT, charger_thermal_pkg::COOL_ISCALE_DEFAULT};
    localparam logic [7:0] ROOM_DEF = {3'h0, charger_thermal_pkg::ROOM_VDROP_DEFAULT,
        charger_thermal_pkg::ROOM_ISCALE_DEFAULT};

    // Room rows walk every current code and every drop code
    row_t rows [10] = '{
        '{8'h16, 8'h00, 8'h00, 4'h2, 8'h96}, '{8'h16, 8'h09, 8'h09, 4'h3, 8'h64},
        '{8'h16, 8'h12, 8'h12, 4'h4, 8'h32}, '{8'h16, 8'h1B, 8'h1B, 4'h5, 8'h00},
        '{8'h16, 8'hE4, 8'h04, 4'h6, 8'h96}, '{8'h16, 8'h2D, 8'h0D, 4'h7, 8'h64},
        '{8'h16, 8'h56, 8'h16, 4'h8, 8'h32}, '{8'h16, 8'hFF, 8'h1F, 4'hA, 8'h00},
        '{8'h15, 8'hFF, 8'h7F, 4'hA, 8'h00}, '{8'h15, 8'h8A, 8'h0A, 4'h4, 8'h00}
    };

    always #25 clock = ~clock;

    charger_thermal_zone_config uut (
        .clock                     (clock),
        .rstn                      (rstn),
        .reg_addr                  (reg_addr),
        .reg_wr                    (reg_wr),
        .reg_wdata                 (reg_wdata),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .charger_input             (charger_input),
        .input_valid_select        (input_valid_select),
        .thermistor_monitor_enable (thm_en),
        .cool_zone_voltage_drop    (cool_drop),
        .cool_zone_current_scale   (cool_scale),
        .room_zone_voltage_drop    (room_drop),
        .room_zone_current_scale   (room_scale),
        .cool_zone_current_tenths  (cool_tenths),
        .room_zone_current_tenths  (room_tenths),
        .room_zone_drop_mv         (room_mv),
        .defaults_restored         (restored)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask : rd

    // Pin change, then a bounded look for the restore pulse
    task automatic pin(input logic [1:0] sel, input logic lvl, output logic hit);
        @(posedge clock);
        input_valid_select <= sel;
        charger_input      <= lvl;
        hit = 1'b0;
        repeat (8) begin
            @(negedge clock);
            if (restored === 1'b1) hit = 1'b1;
        end
    endtask : pin

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic       h;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        rd(8'h15, d); check(d, COOL_DEF);
        rd(8'h16, d); check(d, ROOM_DEF);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, d); check(d, rows[i].rback);
            if (rows[i].addr == 8'h16) begin
                check({5'h0, room_scale}, {5'h0, rows[i].wdata[2:0]});
                check({4'h0, room_tenths}, {4'h0, rows[i].tenths});
                check(room_mv, rows[i].mv);
                check({6'h0, room_drop}, {6'h0, rows[i].wdata[4:3]});
            end else begin
                check({6'h0, cool_drop}, {6'h0, rows[i].wdata[4:3]});
                check({4'h0, cool_tenths}, {4'h0, rows[i].tenths});
                check({5'h0, cool_scale}, {5'h0, rows[i].wdata[2:0]});
                check({6'h0, thm_en}, {6'h0, rows[i].wdata[6:5]});
            end
        end
        // Unmapped address neither reads nor disturbs the cool register
        wr(8'h17, 8'hFF);
        rd(8'h17, d); check(d, 8'h00);
        rd(8'h15, d); check(d, 8'h0A);
        // Rising edge restores with rise select
        wr(8'h15, 8'h6A);
        wr(8'h16, 8'h05);
        pin(2'h1, 1'b1, h); check({7'h0, h}, 8'h01);
        rd(8'h15, d); check(d, COOL_DEF);
        check({4'h0, room_tenths}, {4'h0, charger_thermal_pkg::ISCALE_FULL_TENTH});
        check({6'h0, room_drop}, {6'h0, charger_thermal_pkg::ROOM_VDROP_DEFAULT});
        check({6'h0, thm_en}, {6'h0, charger_thermal_pkg::THM_EN_DEFAULT});
        rd(8'h16, d); check(d, ROOM_DEF);
        // Falling edge ignored under rise select
        wr(8'h16, 8'h05);
        pin(2'h1, 1'b0, h); check({7'h0, h}, 8'h00);
        rd(8'h16, d); check(d, 8'h05);
        // Fall select: rise ignored, fall restores
        pin(2'h2, 1'b1, h); check({7'h0, h}, 8'h00);
        rd(8'h16, d); check(d, 8'h05);
        pin(2'h2, 1'b0, h); check({7'h0, h}, 8'h01);
        rd(8'h16, d); check(d, ROOM_DEF);
        // Never select, then both edges select
        wr(8'h16, 8'h05);
        pin(2'h0, 1'b1, h); check({7'h0, h}, 8'h00);
        pin(2'h0, 1'b0, h); check({7'h0, h}, 8'h00);
        rd(8'h16, d); check(d, 8'h05);
        pin(2'h3, 1'b1, h); check({7'h0, h}, 8'h01);
        wr(8'h16, 8'h05);
        pin(2'h3, 1'b0, h); check({7'h0, h}, 8'h01);
        rd(8'h16, d); check(d, ROOM_DEF);
        // Write landing in the restore cycle is lost: the plug event wins
        wr(8'h16, 8'h05);
        @(posedge clock);
        input_valid_select <= 2'h3;
        charger_input      <= 1'b1;
        repeat (3) @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= 8'h16;
        reg_wdata <= 8'h09;
        @(posedge clock);
        reg_wr    <= 1'b0;
        rd(8'h16, d); check(d, ROOM_DEF);
        pin(2'h0, 1'b0, h); check({7'h0, h}, 8'h00);
        // Reset in mid-run returns both registers to defaults
        wr(8'h15, 8'h6A);
        wr(8'h16, 8'h05);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        rd(8'h15, d); check(d, COOL_DEF);
        rd(8'h16, d); check(d, ROOM_DEF);
        check({4'h0, cool_tenths}, {4'h0, charger_thermal_pkg::ISCALE_FULL_TENTH});
        close_out();
    end

    // Run needs a few hundred cycles; this cuts a hang short
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        close_out();
    end

endmodule : tb
